// ===== hw/tpr_pkg.sv
// Shared constants and carrier types for the timer, prescaler and port block.
`default_nettype none

package tpr_pkg;

  // ==========================================================================
  // Clock and instruction cycle
  // ==========================================================================
  localparam int          CLK_PERIOD_NS  = 4;     // Oscillator period in ns.
  localparam int          PHASE_COUNT    = 4;     // Phases per instr cycle.
  localparam logic [1:0]  PHASE_FIRST    = 2'h0;  // First phase of a cycle.
  localparam logic [1:0]  PHASE_TWO      = 2'h1;  // Second phase.
  localparam logic [1:0]  PHASE_FOUR     = 2'h3;  // Last phase of a cycle.

  // ==========================================================================
  // External clock limits, kept by the source driving the pin
  // ==========================================================================
  localparam int EXT_NOPRE_MARGIN_NS = 20;  // Margin on each level, no divider.
  localparam int EXT_PRE_MARGIN_NS   = 40;  // Margin on the period, divider.
  // Least high or low time without the divider, in clock cycles.
  localparam int EXT_NOPRE_LEVEL_CYC =
    (2 * CLK_PERIOD_NS + EXT_NOPRE_MARGIN_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  // Least period with the divider (before dividing by the ratio), in cycles.
  localparam int EXT_PRE_PERIOD_CYC =
    (4 * CLK_PERIOD_NS + EXT_PRE_MARGIN_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;

  // ==========================================================================
  // Registers
  // ==========================================================================
  localparam logic [7:0] COUNT_REG_ADDR  = 8'h01;  // Address of count register.
  localparam logic [7:0] CONFIG_RESET    = 8'hFF;  // Configuration at reset.
  localparam logic [5:0] DIRECTION_RESET = 6'h3F;  // All pins input at reset.
  localparam logic [7:0] PRESC_RESET     = 8'h00;  // Prescaler at reset.
  localparam logic [1:0] INHIBIT_CYCLES  = 2'h2;   // Cycles held after write.
  localparam int         SHARED_PIN_IDX  = 2;      // Pin shared with timer clk.
  localparam int         INPUT_ONLY_IDX  = 3;      // Pin with no driver.
  localparam int         PORT_WIDTH      = 6;      // Implemented port pins.

  // Configuration register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic       wake_change_disable;    // Bit 7, passed out to the port.
    logic       pullup_disable;         // Bit 6, passed out to the port.
    logic       clock_source_select;    // Bit 5, 1 selects the pin.
    logic       external_edge_select;   // Bit 4, 1 selects falling edges.
    logic       prescaler_assign;       // Bit 3, 1 gives it to the watchdog.
    logic [2:0] prescale_ratio;         // Bits 2..0.
  } tpr_cfg_s;

  // One port request from the processor for the current instruction cycle.
  typedef struct packed {
    logic       write;     // Whole port write of data.
    logic       bit_op;    // Read-modify-write of one bit.
    logic       bit_set;   // Value for the bit operation.
    logic [2:0] bit_idx;   // Bit addressed by the bit operation.
    logic [5:0] data;      // Data for a whole port write.
  } tpr_port_req_s;

endpackage

`default_nettype wire

// ===== hw/tpr_core.sv
// Timer counter, shared prescaler and port access timing in one core.
`timescale 1ns/100ps
`default_nettype none

module tpr_core (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   count_wr,
  input  wire logic [7:0]             count_wr_data,
  output logic      [7:0]             count_rd_data,
  input  wire logic                   config_wr,
  input  wire logic [7:0]             config_wr_data,
  input  wire logic                   direction_wr,
  input  wire logic [5:0]             direction_wr_data,
  input  wire logic                   watchdog_clear_op,
  input  wire logic                   dog_tick_in,
  output logic                        dog_tick_out,
  input  wire tpr_pkg::tpr_port_req_s port_req,
  output logic      [5:0]             port_rd_data,
  input  wire logic [5:0]             port_pin_in,
  output logic      [5:0]             port_pin_out,
  output logic      [5:0]             port_pin_oe,
  output logic      [1:0]             phase,
  output logic                        pullup_disable,
  output logic                        wake_change_disable
);

  // ==========================================================================
  // Helper function
  // ==========================================================================
  // Ones in the low n bits; used for both the counter and watchdog ratios.
  function automatic logic [7:0] low_mask(input logic [3:0] n);
    logic [8:0] wide;
    wide = (9'h001 << n) - 9'h001;
    return wide[7:0];
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  tpr_pkg::tpr_cfg_s cfg;           // Write-only configuration register.
  logic [5:0]        direction;     // Write-only direction register.
  logic [7:0]        presc;         // Shared prescaler, never visible.
  logic [1:0]        inhibit;       // Cycles of counting still held off.
  logic [5:0]        pin_s1;        // First synchroniser stage.
  logic [5:0]        pin_s2;        // Second synchroniser stage.
  logic [5:0]        pin_s3;        // Third synchroniser stage.
  logic [5:0]        pin_level;     // Pin levels once stages two, three agree.
  logic              edge_level_d;  // Previous edge-adjusted timer pin level.
  logic              ext_sample;    // Timer path sampled on phases two, four.
  logic              ext_sample_d;  // Previous sample, for the rising test.

  // ==========================================================================
  // Decode, continuous
  // ==========================================================================
  wire        take        = (phase == tpr_pkg::PHASE_FOUR);
  wire        to_counter  = ~cfg.prescaler_assign;
  wire        from_pin    = cfg.clock_source_select;
  // Edge select inverts the pin so that the chosen edge always rises.
  wire        edge_level  = pin_level[tpr_pkg::SHARED_PIN_IDX]
                            ^ cfg.external_edge_select;
  wire        pin_edge    = edge_level & ~edge_level_d;
  wire [3:0]  tmr_shift   = {1'b0, cfg.prescale_ratio} + 4'h1;
  wire [3:0]  dog_shift   = {1'b0, cfg.prescale_ratio};
  wire [7:0]  tmr_mask    = low_mask(tmr_shift);
  wire [7:0]  dog_mask    = low_mask(dog_shift);
  // Divider output bit: high in the upper half of each divided period.
  wire        presc_out   = presc[cfg.prescale_ratio];
  wire        cycle_tick  = take;
  // The prescaler counts whichever source it is assigned to.
  wire        presc_in    = to_counter ? (from_pin ? pin_edge : cycle_tick)
                                       : dog_tick_in;
  wire        clr_by_wr   = take & count_wr & to_counter;
  wire        clr_by_dog  = take & watchdog_clear_op
                            & cfg.prescaler_assign;
  // Level fed to the phase sampler: the edge-adjusted pin or the divider output.
  wire        ext_level   = to_counter ? presc_out : edge_level;
  wire        ext_rise    = ext_sample & ~ext_sample_d;
  wire        int_inc     = to_counter
                            ? (cycle_tick & ((presc & tmr_mask) == tmr_mask))
                            : cycle_tick;
  wire        any_inc     = (from_pin ? ext_rise : int_inc)
                            & (inhibit == 2'h0);
  wire [7:0]  count_inc   = count_rd_data + 8'h01;
  wire [7:0]  presc_inc   = presc + 8'h01;
  wire        dog_fire    = cfg.prescaler_assign
                            ? (dog_tick_in & ((presc & dog_mask) == dog_mask))
                            : dog_tick_in;

  // Read-modify-write: start from pin levels seen at the start of the cycle,
  // so input pins get their present level copied into their latches.
  logic [5:0] rmw_value;
  always_comb begin
    rmw_value = port_rd_data;
    if (port_req.bit_idx < 3'(tpr_pkg::PORT_WIDTH)) begin
      rmw_value[port_req.bit_idx] = port_req.bit_set;
    end
  end

  wire [5:0] next_latch = port_req.bit_op ? rmw_value
                        : (port_req.write ? port_req.data : port_pin_out);
  wire       latch_load = take & (port_req.bit_op | port_req.write);

  // Driver enables: direction zero drives (never pin three), pin-clock mode frees pin two.
  logic [5:0] next_oe;
  always_comb begin
    next_oe = ~direction;
    next_oe[tpr_pkg::INPUT_ONLY_IDX] = 1'b0;
    if (from_pin) begin
      next_oe[tpr_pkg::SHARED_PIN_IDX] = 1'b0;
    end
  end

  wire [7:0] next_presc = (clr_by_wr | clr_by_dog) ? tpr_pkg::PRESC_RESET
                        : (presc_in ? presc_inc : presc);

  // ==========================================================================
  // Instruction cycle phase
  // ==========================================================================
  // Each clock is one oscillator phase; four make one instruction cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= tpr_pkg::PHASE_FIRST;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ==========================================================================
  // Configuration and direction registers
  // ==========================================================================
  // Both registers load at the end of the instruction that writes them.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg       <= tpr_pkg::CONFIG_RESET;
      direction <= tpr_pkg::DIRECTION_RESET;
    end else begin
      if (take && config_wr) begin
        cfg <= config_wr_data;
      end
      if (take && direction_wr) begin
        direction <= direction_wr_data;
      end
    end
  end

  // Side bits of the configuration leave as registered levels.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pullup_disable      <= 1'b1;
      wake_change_disable <= 1'b1;
    end else begin
      pullup_disable      <= cfg.pullup_disable;
      wake_change_disable <= cfg.wake_change_disable;
    end
  end

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  // Three stages; a level counts only once stages two and three agree, so a
  // single metastable resolution cannot produce a false edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1    <= 6'h00;
      pin_s2    <= 6'h00;
      pin_s3    <= 6'h00;
      pin_level <= 6'h00;
    end else begin
      pin_s1    <= port_pin_in;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_level <= (pin_s2 & ~(pin_s2 ^ pin_s3))
                 | (pin_level & (pin_s2 ^ pin_s3));
    end
  end

  // ==========================================================================
  // Timer pin edge and phase sampling
  // ==========================================================================
  // The timer path is sampled only on phases two and four, which is what
  // bounds the least pin high and low times on the source side.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Reset to the idle edge level of the reset configuration (falling
      // edge select, pin low reads high), so leaving reset is no edge.
      edge_level_d <= 1'b1;
      ext_sample   <= 1'b1;
      ext_sample_d <= 1'b1;
    end else begin
      edge_level_d <= edge_level;
      if (phase == tpr_pkg::PHASE_TWO || phase == tpr_pkg::PHASE_FOUR) begin
        ext_sample <= ext_level;
      end
      ext_sample_d <= ext_sample;
    end
  end

  // ==========================================================================
  // Prescaler
  // ==========================================================================
  // One counter for both users; clearing follows whichever owns it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc <= tpr_pkg::PRESC_RESET;
    end else begin
      presc <= next_presc;
    end
  end

  // Watchdog tick after division while it owns the prescaler, passed through undivided otherwise.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dog_tick_out <= 1'b0;
    end else begin
      dog_tick_out <= dog_fire;
    end
  end

  // ==========================================================================
  // Count register
  // ==========================================================================
  // A write wins over an increment in the same cycle and arms the hold-off;
  // software that wants exact time must write an adjusted value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_rd_data <= 8'h00;
      inhibit       <= 2'h0;
    end else begin
      if (take && count_wr) begin
        count_rd_data <= count_wr_data;
        inhibit       <= tpr_pkg::INHIBIT_CYCLES;
      end else begin
        if (any_inc) begin
          count_rd_data <= count_inc;
        end
        if (take && inhibit != 2'h0) begin
          inhibit <= inhibit - 2'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Port latches, driver enables and read snapshot
  // ==========================================================================
  // Pins are sampled in the first phase; latches change at cycle end. A read
  // right after a write therefore sees the old pin level.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_pin_out <= 6'h00;
      port_pin_oe  <= 6'h00;
      port_rd_data <= 6'h00;
    end else begin
      if (latch_load) begin
        port_pin_out <= next_latch;
      end
      port_pin_oe <= next_oe;
      if (phase == tpr_pkg::PHASE_FIRST) begin
        port_rd_data <= pin_level;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [7:0] last_wr_data;  // Value of the latest taken count write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_wr_data <= 8'h00;
    end else if (take && count_wr) begin
      last_wr_data <= count_wr_data;
    end
  end

  AST_WRITE_HOLD: assert property (
    (take && count_wr) |=> (count_rd_data == last_wr_data) [*8])
    else $error("Count moved during write hold-off.");

  AST_PRESC_CLR_WR: assert property (
    clr_by_wr |=> (presc == 8'h00))
    else $error("Count write did not clear prescaler.");

  AST_PRESC_CLR_DOG: assert property (
    clr_by_dog |=> (presc == 8'h00))
    else $error("Watchdog clear did not clear prescaler.");

  AST_FORCE_INPUT: assert property (
    from_pin |=> !port_pin_oe[tpr_pkg::SHARED_PIN_IDX])
    else $error("Shared pin driven in pin clock mode.");

  AST_DIR_DRIVE: assert property (
    (take && direction_wr && !from_pin) |-> ##2
      (port_pin_oe[0] == !$past(direction_wr_data[0], 2)))
    else $error("Driver enable does not follow direction.");

  AST_TIMER_STEP: assert property (
    (take && !from_pin && cfg.prescaler_assign && inhibit == 2'h0
      && !count_wr) |=> (count_rd_data == 8'($past(count_rd_data) + 8'h01)))
    else $error("Timer did not advance once per cycle.");

  AST_PORT_WRITE: assert property (
    (take && port_req.write && !port_req.bit_op) |=>
      (port_pin_out == $past(port_req.data)))
    else $error("Port write not latched at cycle end.");

  AST_BIT_OP: assert property (
    (take && port_req.bit_op && port_req.bit_idx == 3'h0) |=>
      (port_pin_out[0] == $past(port_req.bit_set))
      && (port_pin_out[5:1] == $past(port_rd_data[5:1])))
    else $error("Bit operation did not rewrite pin levels.");

  AST_READ_START: assert property (
    (phase == tpr_pkg::PHASE_FIRST) |=> (port_rd_data == $past(pin_level))
      ##1 $stable(port_rd_data) [*3])
    else $error("Port read not sampled at cycle start.");

  AST_EXT_PHASE: assert property (
    (from_pin && inhibit == 2'h0 && !(take && count_wr)
      && $changed(ext_sample) == 1'b0 && !ext_rise) |=>
      (count_rd_data == $past(count_rd_data)) || $past(take && count_wr))
    else $error("Pin increment without a synchronised edge.");

endmodule

`default_nettype wire

// ===== bench/tpr_pin_src.sv
// Behavioural source that drives the external timer clock pin.
`timescale 1ns/100ps
`default_nettype none

module tpr_pin_src (
  output logic pin  // Timer clock pin level.
);
  // The pin rests low between bursts; this source never runs free.
  initial pin = 1'b0;

  // ==========================================================================
  // Burst of pulses
  // ==========================================================================
  // Sends n pulses. Short requests are stretched, so the source is never
  // harsher or faster than the pin may legally be driven.
  task automatic burst(input int n, input int hi, input int lo);
    int h;
    int l;
    h = (hi < tpr_pkg::EXT_NOPRE_LEVEL_CYC) ?
        tpr_pkg::EXT_NOPRE_LEVEL_CYC : hi;
    l = (lo < tpr_pkg::EXT_NOPRE_LEVEL_CYC) ?
        tpr_pkg::EXT_NOPRE_LEVEL_CYC : lo;
    if (h + l < tpr_pkg::EXT_PRE_PERIOD_CYC) begin
      l = tpr_pkg::EXT_PRE_PERIOD_CYC - h;
    end
    #1.3;  // Off-grid start, so pin edges are unrelated to the clock.
    repeat (n) begin
      pin = 1'b1;
      #(h * tpr_pkg::CLK_PERIOD_NS);
      pin = 1'b0;
      #(l * tpr_pkg::CLK_PERIOD_NS);
    end
  endtask
endmodule

`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking testbench for the timer, prescaler and port core.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic                  clk;          // 250 MHz clock.
  logic                  resetn;       // Active low reset.
  logic [4:0]            stb;          // Count, config, dir, clear, port.
  logic [7:0]            cwd;          // Count write data.
  logic [7:0]            fwd;          // Config write data.
  logic [5:0]            dwd;          // Direction write data.
  tpr_pkg::tpr_port_req_s preq;        // Port request contents.
  wire tpr_pkg::tpr_port_req_s req_w;  // Port request while strobed.
  logic                  tick;         // Raw watchdog tick.
  logic [5:0]            pins;         // Levels driven on the port.
  wire logic             src_pin;      // Timer clock pin from the source.
  wire logic [5:0]       pin_in;       // Port levels seen by the core.
  wire logic [7:0]       count;        // Count register.
  wire logic [5:0]       rd;           // Port read data.
  wire logic [5:0]       pout;         // Output latches.
  wire logic [5:0]       oe;           // Driver enables.
  wire logic [1:0]       phase;        // Instruction phase.
  wire logic             pud;          // Pull-up disable.
  wire logic             wcd;          // Wake on change disable.
  wire logic             dto;          // Divided watchdog tick.
  int                    mismatches;   // Failed comparisons.
  int                    n_compared;   // All comparisons.
  int                    dog_n;        // Divided ticks seen.

  assign req_w  = stb[4] ? preq : '0;
  assign pin_in = {pins[5:3], src_pin, pins[1:0]};

  tpr_pin_src src (.pin(src_pin));

  tpr_core dut (
    .clk(clk), .resetn(resetn), .count_wr(stb[0]), .count_wr_data(cwd),
    .count_rd_data(count), .config_wr(stb[1]), .config_wr_data(fwd),
    .direction_wr(stb[2]), .direction_wr_data(dwd),
    .watchdog_clear_op(stb[3]), .dog_tick_in(tick), .dog_tick_out(dto),
    .port_req(req_w), .port_rd_data(rd), .port_pin_in(pin_in),
    .port_pin_out(pout), .port_pin_oe(oe), .phase(phase),
    .pullup_disable(pud), .wake_change_disable(wcd)
  );

  // ==========================================================================
  // Clock and monitors
  // ==========================================================================
  // Free-running clock, inverted every half period.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Counts divided watchdog ticks as they leave the core.
  always @(posedge clk) begin
    if (dto === 1'b1) begin
      dog_n++;
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Prints the verdict and stops the run.
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compares one value against its expectation.
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits n falling edges.
  task automatic wcyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Raises one strobe across the last phase, where requests are taken.
  task automatic step(input int w);
    int i;
    for (i = 0; i < 16 && phase !== 2'h3; i++) @(negedge clk);
    if (phase !== 2'h3) begin
      mismatches++;
      conclude();
    end else begin
      stb[w] = 1'b1;
      @(negedge clk);
      stb = '0;
    end
  endtask

  // Sends n raw watchdog ticks, spaced apart.
  task automatic tick_n(input int n);
    repeat (n) begin
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      wcyc(3);
    end
  endtask

  // Writes the configuration register.
  task automatic cfg(input logic [7:0] v);
    fwd = v;
    step(1);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Hold-off after a count write, then one step per cycle with wrap.
  task automatic t_timer();
    cfg(8'h08);
    wcyc(2);
    chk("oe", 8'h00, {2'h0, oe});
    chk("flags", 8'h00, {6'h00, wcd, pud});
    cwd = 8'hFE;
    step(0);
    chk("count", 8'hFE, count);
    wcyc(8);
    chk("count", 8'hFE, count);
    wcyc(4);
    chk("count", 8'hFF, count);
    wcyc(12);
    chk("count", 8'h02, count);
  endtask

  // Every ratio code: one step per 2^(ratio+1) cycles.
  task automatic t_presc();
    logic [7:0] a;
    for (int r = 0; r < 8; r++) begin
      cfg({5'h00, 3'(r)});
      wcyc(8);
      a = count;
      wcyc(8 << (r + 1));
      chk("ratio", a + 8'h02, count);
    end
  endtask

  // Bit operations rewrite every latch from the pins.
  task automatic t_port();
    cfg(8'h08);
    dwd = 6'h00;
    step(2);
    wcyc(2);
    chk("oe", 8'h37, {2'h0, oe});
    pins = 6'b110001;
    preq = '0;
    preq.write = 1'b1;
    preq.data = 6'h0E;
    step(4);
    wcyc(8);
    chk("latch", 8'h0E, {2'h0, pout});
    chk("read", 8'h31, {2'h0, rd});
    preq = '0;
    preq.bit_op = 1'b1;
    preq.bit_set = 1'b1;
    preq.bit_idx = 3'h1;
    step(4);
    wcyc(2);
    chk("latch", 8'h33, {2'h0, pout});
    preq.bit_set = 1'b0;
    preq.bit_idx = 3'h5;
    step(4);
    wcyc(2);
    chk("latch", 8'h11, {2'h0, pout});
    preq.bit_idx = 3'h0;
    step(4);
    wcyc(2);
    chk("latch", 8'h30, {2'h0, pout});
  endtask

  // Pin source on both edges; the shared pin is forced to input.
  task automatic t_pin();
    logic [7:0] a;
    cfg(8'h28);
    wcyc(8);
    chk("oe", 8'h33, {2'h0, oe});
    a = count;
    src.burst(3, 8, 8);
    wcyc(20);
    chk("pin rise", a + 8'h03, count);
    cfg(8'h38);
    wcyc(8);
    a = count;
    src.burst(2, 8, 8);
    wcyc(20);
    chk("pin fall", a + 8'h02, count);
    // Pin through the divider: clear it by a count write, wait out the
    // hold-off, then four pin edges give two counts at ratio code zero.
    cfg(8'h20);
    cwd = 8'h00;
    step(0);
    wcyc(12);
    src.burst(4, 8, 8);
    wcyc(20);
    chk("pin presc", 8'h02, count);
  endtask

  // Watchdog division, clear, and handover to the counter.
  task automatic t_dog();
    step(3);
    cwd = 8'h00;
    step(0);
    cfg(8'h09);
    dog_n = 0;
    tick_n(4);
    wcyc(2);
    chk("dog", 8'h02, 8'(dog_n));
    dog_n = 0;
    tick_n(1);
    step(3);
    tick_n(1);
    wcyc(2);
    chk("dog clr", 8'h00, 8'(dog_n));
    step(3);
    cfg(8'h01);
    dog_n = 0;
    tick_n(3);
    wcyc(2);
    chk("dog pass", 8'h03, 8'(dog_n));
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    resetn = 1'b0;
    stb = '0;
    cwd = '0;
    fwd = '0;
    dwd = '0;
    preq = '0;
    tick = 1'b0;
    pins = '0;
    mismatches = 0;
    n_compared = 0;
    dog_n = 0;
    repeat (12) @(negedge clk);
    chk("count", 8'h00, count);
    chk("flags", 8'h03, {6'h00, wcd, pud});
    resetn = 1'b1;
    wcyc(2);
    // Reset configuration gives the watchdog the divider at its top ratio:
    // from zero, the first divided tick leaves on raw tick 128.
    tick_n(127);
    chk("presc reset", 8'h00, 8'(dog_n));
    tick_n(1);
    chk("presc reset", 8'h01, 8'(dog_n));
    t_timer();
    t_presc();
    t_port();
    t_pin();
    t_dog();
    conclude();
  end
endmodule

`default_nettype wire
